// ===== drive_flags_pkg.sv
// Shared constants, selection codes and types for the drive status flags
// Contract
// R1: Overload notice 1 code 03, 2 code 21
// R2: Notice 1 on above level 1, off below
// R3: Notice 2 on above level 2, off below
// R4: Overload levels 0.0-2.0 times rated current
// R5: Overload restriction lowers frequency while accelerating
// R6: PID deviation flag code 04 above limit
// R7: Alarm code 5 held until alarm reset
// R8: Relay defaults to alarm; terminals may too
// R9: Over-torque versus per-quadrant level, four levels
// R10: Over-torque code 7 only under vector methods
// R11: Power loss code 08, undervoltage code 09
// R12: Torque-limited code 10 only methods 5-7
// R13: Hours flags at or above hours limit
// R14: Run hours code 11, power-on code 12
// R15: Thermal warning code 13 below setting off
// R16: Brake release code 14, fault code 15
// R17: Zero-speed code 16 below zero-speed level
// R18: Zero-speed source ramp, or rotor when sensored
// R19: Far side tolerates alarm delay, chatter
// R20: Each terminal drives its selected flag
package drive_flags_pkg;
  // Selection code width and flag vector size
  localparam int SEL_W = 5;
  localparam int NFLAGS = 32;
  // Flag selection codes
  localparam logic [4:0] CODE_OVERLOAD_1 = 5'h03;
  localparam logic [4:0] CODE_PID_DEV = 5'h04;
  localparam logic [4:0] CODE_ALARM = 5'h05;
  localparam logic [4:0] CODE_OVER_TORQUE = 5'h07;
  localparam logic [4:0] CODE_POWER_LOSS = 5'h08;
  localparam logic [4:0] CODE_UNDERVOLT = 5'h09;
  localparam logic [4:0] CODE_TORQUE_LIM = 5'h0A;
  localparam logic [4:0] CODE_RUN_HOURS = 5'h0B;
  localparam logic [4:0] CODE_ON_HOURS = 5'h0C;
  localparam logic [4:0] CODE_THERMAL = 5'h0D;
  localparam logic [4:0] CODE_BRAKE_REL = 5'h0E;
  localparam logic [4:0] CODE_BRAKE_FAULT = 5'h0F;
  localparam logic [4:0] CODE_ZERO_SPEED = 5'h10;
  localparam logic [4:0] CODE_OVERLOAD_2 = 5'h15;
  localparam logic [4:0] CODE_NONE = 5'h1F;
  // Selections after reset
  localparam logic [4:0] TERM_SEL_RST = CODE_NONE;
  localparam logic [4:0] RELAY_SEL_RST = CODE_ALARM;
  // Motor control method codes
  localparam logic [2:0] METHOD_SENSORLESS = 3'h5;
  localparam logic [2:0] METHOD_SENSORED = 3'h6;
  localparam logic [2:0] METHOD_ZERO_HZ = 3'h7;
  // Per-mille of rated current for one level step, a tenth of rated
  localparam logic [11:0] LEVEL_SCALE = 12'h064;
  // Clock and timing
  localparam longint CLK_HZ = 64'h0000_0000_05F5_E100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESTRICT_STEP_NS = 1000000;
  localparam int RESTRICT_STEP_CYCLES = RESTRICT_STEP_NS / CLK_PERIOD_NS;
  localparam longint HOUR_S = 64'h0000_0000_0000_0E10;
  localparam longint HOUR_CYCLES = HOUR_S * CLK_HZ;
  // Hour counters saturate here
  localparam logic [13:0] HOURS_SAT = 14'h3FFF;
  // Frequency output after reset
  localparam logic [15:0] FREQ_RST = 16'h0000;
  // Overload restriction states
  typedef enum logic [1:0] {
    RS_FOLLOW = 2'b01,
    RS_RESTRICT = 2'b10
  } restrict_state_t;
endpackage

// ===== flag_bus_if.sv
// Carrier of the flag vector from the flag generator to the terminal routers
`timescale 1ns/1ps
interface flag_bus_if;
  // One flag per selection code
  logic [31:0] flags;
  modport source(output flags);
  modport sink(input flags);
endinterface

// ===== hour_meter.sv
// Accumulated hours counter with an hour prescaler
`timescale 1ns/1ps
module hour_meter #(
  parameter longint CYCLES_PER_HOUR = drive_flags_pkg::HOUR_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Counting enable and result
  input wire logic count_en,
  output logic [13:0] hours
);
  // Prescaler wide enough for a full hour at the system clock
  logic [39:0] prescale;
  logic hour_tick;

  if (CYCLES_PER_HOUR < 1 || CYCLES_PER_HOUR > 64'h0000_00FF_FFFF_FFFF) begin : g_chk
    $error("hour_meter: cycles per hour out of range");
  end

  // Tick on the last cycle of each counted hour
  assign hour_tick = count_en && (prescale == 40'(CYCLES_PER_HOUR - 64'h1));

  // Prescaler only advances while counting, so partial hours are kept
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prescale <= '0;
      hours <= '0;
    end else if (hour_tick) begin
      prescale <= '0;
      // Saturate instead of wrapping back below the limit
      if (hours != drive_flags_pkg::HOURS_SAT) begin
        hours <= hours + 14'h0001;
      end
    end else if (count_en) begin
      prescale <= prescale + 40'h00_0000_0001;
    end
  end
endmodule

// ===== terminal_mux.sv
// Router from the flag vector to one output terminal
`timescale 1ns/1ps
module terminal_mux (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Flags and selection
  flag_bus_if.sink bus,
  input wire logic [4:0] sel,
  // Terminal drive
  output logic term_out
);
  // Selected flag, undefined codes read as zero in the vector
  wire picked = bus.flags[sel];

  // Registered so the terminal never glitches between codes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      term_out <= 1'b0;
    end else begin
      term_out <= picked; // [R20]
    end
  end
endmodule

// ===== drive_status_output_flags.sv
// Drive status flag generator with terminal and relay routing
`timescale 1ns/1ps
module drive_status_output_flags #(
  parameter int RESTRICT_STEP = drive_flags_pkg::RESTRICT_STEP_CYCLES,
  parameter longint CYCLES_PER_HOUR = drive_flags_pkg::HOUR_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Selection settings, one write strobe per terminal, index 4 is the relay
  input wire logic [4:0] sel_wr,
  input wire logic [4:0] sel_data,
  // Current, per-mille of rated, and levels in tenths of rated
  input wire logic [11:0] output_current,
  input wire logic [4:0] overload_level_1,
  input wire logic [4:0] overload_level_2,
  input wire logic [4:0] restrict_level,
  // Acceleration and constant speed indications
  input wire logic accelerating,
  input wire logic constant_speed,
  // PID error magnitude and limit, tenths of a percent
  input wire logic [10:0] pid_error,
  input wire logic [9:0] pid_deviation_limit,
  // Fault events and alarm reset, one-cycle pulses
  input wire logic fault_event,
  input wire logic alarm_reset,
  // Torque estimate in percent, signed, and rotation direction
  input wire logic signed [9:0] torque_est,
  input wire logic dir_reverse,
  input wire logic [7:0] torque_level_fwd_drive,
  input wire logic [7:0] torque_level_rev_regen,
  input wire logic [7:0] torque_level_rev_drive,
  input wire logic [7:0] torque_level_fwd_regen,
  input wire logic [2:0] motor_control_method,
  // Supply and limiter states
  input wire logic momentary_power_loss,
  input wire logic undervoltage_flag,
  input wire logic torque_limit_active,
  // Hours
  input wire logic running,
  input wire logic [13:0] hours_limit,
  // Thermal
  input wire logic [9:0] thermal_value,
  input wire logic [9:0] thermal_warning_level,
  // Brake control
  input wire logic brake_release,
  input wire logic brake_fault,
  // Speed sources and zero-speed level, 0.01 Hz units
  input wire logic [15:0] ramp_output,
  input wire logic [15:0] rotor_freq,
  input wire logic [13:0] zero_speed_level,
  // Terminal and relay drive
  output logic [3:0] terminal_out,
  output logic relay_out,
  // Frequency command after overload restriction
  output logic [15:0] freq_out,
  output logic restricting
);
  // Elaboration checks
  if (RESTRICT_STEP < 1 || RESTRICT_STEP > 32'h00FF_FFFF) begin : g_chk_step
    $error("restriction step out of range");
  end
  if (CYCLES_PER_HOUR < 1) begin : g_chk_hour
    $error("cycles per hour out of range");
  end

  // Level in tenths of rated converted to per-mille of rated current
  function automatic logic [11:0] level_to_current(input logic [4:0] lvl);
    logic [16:0] prod;
    prod = 17'(lvl) * 17'(drive_flags_pkg::LEVEL_SCALE);
    return prod[11:0];
  endfunction

  // Vector methods: sensorless, sensored and zero-hertz
  function automatic logic is_vector(input logic [2:0] m);
    return (m == drive_flags_pkg::METHOD_SENSORLESS) ||
           (m == drive_flags_pkg::METHOD_SENSORED) || (m == drive_flags_pkg::METHOD_ZERO_HZ);
  endfunction

  // Selection registers, index 4 is the relay
  logic [4:0] sel [0:4];
  // Registered flags
  logic ovl1, ovl2, pid_dev, alarm, over_torque, torque_lim;
  logic run_over, on_over, thermal_warn, zero_speed;
  logic power_loss_q, undervolt_q, brake_rel_q, brake_fault_q;
  // Hour counts
  logic [13:0] run_hours, on_hours;
  // Restriction machinery
  drive_flags_pkg::restrict_state_t rs_state, next_rs_state;
  logic [23:0] step_cnt;
  logic step_tick;

  // Thresholds derived from the level settings
  wire [11:0] thr1 = level_to_current(overload_level_1); // [R4]
  wire [11:0] thr2 = level_to_current(overload_level_2); // [R4]
  wire [11:0] thr_restrict = level_to_current(restrict_level);

  // Quadrant: positive torque drives forward and regenerates in reverse
  wire torque_neg = torque_est[9];
  wire [9:0] torque_mag = torque_neg ? 10'(-torque_est) : 10'(torque_est);
  wire [7:0] quad_level = dir_reverse ?
                          (torque_neg ? torque_level_rev_drive : torque_level_rev_regen) :
                          (torque_neg ? torque_level_fwd_regen : torque_level_fwd_drive);
  wire vector_method = is_vector(motor_control_method);
  wire torque_over_cond = vector_method && (torque_mag > {2'b00, quad_level}); // [R9] [R10]

  // Zero-speed source: rotor frequency when sensored, ramp otherwise
  wire use_rotor = motor_control_method == drive_flags_pkg::METHOD_SENSORED;
  wire [15:0] speed_src = use_rotor ? rotor_freq : ramp_output; // [R18]
  wire zero_cond = speed_src < {2'b00, zero_speed_level}; // [R17]

  // Overload restriction applies only on acceleration or constant speed
  wire restrict_window = accelerating || constant_speed;
  wire over_restrict = restrict_window && (output_current >= thr_restrict);

  // Selection settings, relay starts on the alarm
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        sel[i] <= drive_flags_pkg::TERM_SEL_RST;
      end
      sel[4] <= drive_flags_pkg::RELAY_SEL_RST; // [R8]
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (sel_wr[i]) begin
          sel[i] <= sel_data;
        end
      end
    end
  end

  // Level comparisons registered once; equality keeps the overload notices, PID flag clears
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ovl1 <= 1'b0;
      ovl2 <= 1'b0;
      pid_dev <= 1'b0;
    end else begin
      // Hold at exact equality, a tiny built-in hysteresis
      if (output_current > thr1) begin
        ovl1 <= 1'b1; // [R2]
      end else if (output_current < thr1) begin
        ovl1 <= 1'b0; // [R2]
      end
      if (output_current > thr2) begin
        ovl2 <= 1'b1; // [R3]
      end else if (output_current < thr2) begin
        ovl2 <= 1'b0; // [R3]
      end
      pid_dev <= pid_error > {1'b0, pid_deviation_limit}; // [R6]
    end
  end

  // Alarm latch; a fault in the reset cycle wins so no fault is lost
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      alarm <= 1'b0;
    end else if (fault_event) begin
      alarm <= 1'b1; // [R7]
    end else if (alarm_reset) begin
      alarm <= 1'b0; // [R7]
    end
  end

  // Torque, supply, thermal, brake, speed and hours flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      over_torque <= 1'b0;
      torque_lim <= 1'b0;
      power_loss_q <= 1'b0;
      undervolt_q <= 1'b0;
      thermal_warn <= 1'b0;
      brake_rel_q <= 1'b0;
      brake_fault_q <= 1'b0;
      zero_speed <= 1'b0;
      run_over <= 1'b0;
      on_over <= 1'b0;
    end else begin
      over_torque <= torque_over_cond; // [R9] [R10]
      torque_lim <= torque_limit_active && vector_method; // [R12]
      power_loss_q <= momentary_power_loss; // [R11]
      undervolt_q <= undervoltage_flag; // [R11]
      thermal_warn <= thermal_value >= thermal_warning_level; // [R15]
      brake_rel_q <= brake_release; // [R16]
      brake_fault_q <= brake_fault; // [R16]
      zero_speed <= zero_cond; // [R17]
      run_over <= run_hours >= hours_limit; // [R13]
      on_over <= on_hours >= hours_limit; // [R13]
    end
  end

  // Hour meters: run time counts while running, power-on time always
  hour_meter #(.CYCLES_PER_HOUR(CYCLES_PER_HOUR)) u_run_hours (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .count_en(running),
    .hours(run_hours)
  );
  hour_meter #(.CYCLES_PER_HOUR(CYCLES_PER_HOUR)) u_on_hours (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .count_en(1'b1),
    .hours(on_hours)
  );

  // Flag vector indexed by selection code; unlisted codes stay low
  flag_bus_if fbus ();
  always_comb begin
    fbus.flags = '0;
    fbus.flags[drive_flags_pkg::CODE_OVERLOAD_1] = ovl1; // [R1]
    fbus.flags[drive_flags_pkg::CODE_OVERLOAD_2] = ovl2; // [R1]
    fbus.flags[drive_flags_pkg::CODE_PID_DEV] = pid_dev; // [R6]
    fbus.flags[drive_flags_pkg::CODE_ALARM] = alarm; // [R7] [R8]
    fbus.flags[drive_flags_pkg::CODE_OVER_TORQUE] = over_torque; // [R10]
    fbus.flags[drive_flags_pkg::CODE_POWER_LOSS] = power_loss_q; // [R11]
    fbus.flags[drive_flags_pkg::CODE_UNDERVOLT] = undervolt_q; // [R11]
    fbus.flags[drive_flags_pkg::CODE_TORQUE_LIM] = torque_lim; // [R12]
    fbus.flags[drive_flags_pkg::CODE_RUN_HOURS] = run_over; // [R14]
    fbus.flags[drive_flags_pkg::CODE_ON_HOURS] = on_over; // [R14]
    fbus.flags[drive_flags_pkg::CODE_THERMAL] = thermal_warn; // [R15]
    fbus.flags[drive_flags_pkg::CODE_BRAKE_REL] = brake_rel_q; // [R16]
    fbus.flags[drive_flags_pkg::CODE_BRAKE_FAULT] = brake_fault_q; // [R16]
    fbus.flags[drive_flags_pkg::CODE_ZERO_SPEED] = zero_speed; // [R17]
  end

  // Four open-collector terminals and the relay, each with its own router
  for (genvar t = 0; t < 4; t++) begin : g_term
    terminal_mux u_mux (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .bus(fbus.sink),
      .sel(sel[t]),
      .term_out(terminal_out[t])
    );
  end
  terminal_mux u_relay (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bus(fbus.sink),
    .sel(sel[4]),
    .term_out(relay_out)
  );

  // Step divider: one-cycle enable per restriction step
  assign step_tick = step_cnt == 24'(RESTRICT_STEP - 1);
  always_ff @(posedge clk_sys) begin
    if (!rst_n || step_tick) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= step_cnt + 24'h00_0001;
    end
  end

  // Restriction state: enter on overload in the window, leave once current drops or the window closes
  always_comb begin
    case (rs_state)
      drive_flags_pkg::RS_FOLLOW: begin
        next_rs_state = over_restrict ? drive_flags_pkg::RS_RESTRICT : drive_flags_pkg::RS_FOLLOW;
      end
      drive_flags_pkg::RS_RESTRICT: begin
        next_rs_state = over_restrict ? drive_flags_pkg::RS_RESTRICT : drive_flags_pkg::RS_FOLLOW;
      end
      default: begin
        next_rs_state = drive_flags_pkg::RS_FOLLOW;
      end
    endcase
  end

  // Frequency follows the ramp, or steps down while restricting.
  // Stepping slowly trades response for avoiding a regenerative surge.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rs_state <= drive_flags_pkg::RS_FOLLOW;
      freq_out <= drive_flags_pkg::FREQ_RST;
      restricting <= 1'b0;
    end else begin
      rs_state <= next_rs_state;
      restricting <= next_rs_state == drive_flags_pkg::RS_RESTRICT;
      if (rs_state == drive_flags_pkg::RS_RESTRICT) begin
        if (step_tick && freq_out != 16'h0000) begin
          freq_out <= freq_out - 16'h0001; // [R5]
        end
      end else begin
        freq_out <= ramp_output;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  overload_route_a: assert property ( // [R2] [R20]
    (output_current > thr1) && sel[0] == drive_flags_pkg::CODE_OVERLOAD_1
    ##1 sel[0] == drive_flags_pkg::CODE_OVERLOAD_1 |=> terminal_out[0])
    else $error("overload notice 1 not routed to terminal 0");
  overload_two_a: assert property ( // [R3]
    (output_current < thr2) |=> !ovl2)
    else $error("overload notice 2 set below its level");
  alarm_set_a: assert property ( // [R7]
    fault_event |=> alarm)
    else $error("fault did not latch the alarm");
  alarm_hold_a: assert property ( // [R7]
    alarm && !alarm_reset |=> alarm)
    else $error("alarm dropped without reset");
  alarm_clear_a: assert property ( // [R7]
    alarm_reset && !fault_event |=> !alarm)
    else $error("alarm survived its reset");
  relay_default_a: assert property ( // [R8]
    $rose(rst_n) ##0 (sel_wr == 5'h00) [*3] ##0 alarm |-> ##1 relay_out)
    else $error("relay does not carry the alarm after reset");
  torque_method_a: assert property ( // [R10] [R12]
    !is_vector(motor_control_method) |=> !over_torque && !torque_lim)
    else $error("torque flag outside vector methods");
  pid_dev_a: assert property ( // [R6]
    pid_error > {1'b0, pid_deviation_limit} |=> pid_dev)
    else $error("PID deviation flag missed");
  zero_rotor_a: assert property ( // [R18]
    use_rotor && (rotor_freq >= {2'b00, zero_speed_level}) |=> !zero_speed)
    else $error("zero-speed flag from wrong source");
  hours_a: assert property ( // [R13]
    (run_hours >= hours_limit) && $stable(hours_limit) |=> run_over)
    else $error("run hours flag missed");
  restrict_step_a: assert property ( // [R5]
    rs_state == drive_flags_pkg::RS_RESTRICT && step_tick && freq_out != 16'h0000
    |=> freq_out == $past(freq_out) - 16'h0001)
    else $error("restriction did not lower the frequency");
endmodule

// ===== flag_reader.sv
// External controller model that reads the drive relay as an interlock input
`timescale 1ns/1ps
module flag_reader #(
  parameter int SETTLE = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Relay contact from the drive
  input wire logic relay_out,
  // Debounced alarm as the controller sees it
  output logic alarm_seen
);
  // Cycles the contact has stayed closed
  logic [7:0] on_count;
  // Chatter or a late contact only restarts the count, never trips the interlock
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !relay_out) begin
      on_count <= 8'h00;
    end else if (on_count != SETTLE[7:0]) begin
      on_count <= on_count + 8'h01;
    end
  end
  // Interlock engages once the contact has settled
  assign alarm_seen = (on_count == SETTLE[7:0]);
endmodule

// ===== tb_drive_status_output_flags.sv
// Self-checking testbench for the drive status flag generator
`timescale 1ns/1ps
module tb_drive_status_output_flags;
  // Clock and reset
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  // Selections and levels
  logic [4:0] sel_wr, sel_data, overload_level_1, overload_level_2, restrict_level;
  logic [11:0] output_current;
  logic accelerating, constant_speed, fault_event, alarm_reset, dir_reverse;
  logic [10:0] pid_error;
  logic [9:0] pid_deviation_limit, thermal_value, thermal_warning_level;
  logic signed [9:0] torque_est;
  logic [7:0] torque_level_fwd_drive, torque_level_rev_regen;
  logic [7:0] torque_level_rev_drive, torque_level_fwd_regen;
  logic [2:0] motor_control_method;
  logic momentary_power_loss, undervoltage_flag, torque_limit_active, running;
  logic brake_release, brake_fault;
  logic [13:0] hours_limit, zero_speed_level;
  logic [15:0] ramp_output, rotor_freq;
  // Outputs
  logic [3:0] terminal_out;
  logic relay_out, restricting, alarm_seen;
  logic [15:0] freq_out;
  int num_errors = 0;
  int check_count = 0;
  // Short counts keep the run brief
  drive_status_output_flags #(.RESTRICT_STEP(4), .CYCLES_PER_HOUR(10))
    drive_status_output_flags_inst (.clk_sys, .rst_n, .sel_wr, .sel_data, .output_current,
    .overload_level_1, .overload_level_2, .restrict_level, .accelerating, .constant_speed,
    .pid_error, .pid_deviation_limit, .fault_event, .alarm_reset, .torque_est, .dir_reverse,
    .torque_level_fwd_drive, .torque_level_rev_regen, .torque_level_rev_drive,
    .torque_level_fwd_regen, .motor_control_method, .momentary_power_loss,
    .undervoltage_flag, .torque_limit_active, .running, .hours_limit, .thermal_value,
    .thermal_warning_level, .brake_release, .brake_fault, .ramp_output, .rotor_freq,
    .zero_speed_level, .terminal_out, .relay_out, .freq_out, .restricting);
  flag_reader flag_reader_inst (.clk_sys, .rst_n, .relay_out, .alarm_seen);
  // Clock
  always #5 clk_sys = ~clk_sys;
  // Move just past the sampling edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Compare one flag
  task automatic chk(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %b", $time, what, got);
    end
  endtask
  // One-cycle selection write, then an idle cycle so writes never abut
  task automatic set_sel(input logic [4:0] mask, input logic [4:0] code);
    sel_wr = mask;
    sel_data = code;
    tick(1);
    sel_wr = 5'h00;
    tick(1);
  endtask
  // Alarm before any write shows the relay default; then hold, collision, clear
  task automatic t_alarm();
    fault_event = 1'b1;
    tick(1);
    fault_event = 1'b0;
    tick(1);
    set_sel(5'h01, drive_flags_pkg::CODE_ALARM);
    chk(relay_out, 1'b1, "relay alarm");
    chk(terminal_out[0], 1'b1, "terminal alarm");
    tick(10);
    chk(relay_out, 1'b1, "alarm held");
    chk(alarm_seen, 1'b1, "reader interlock");
    {fault_event, alarm_reset} = 2'b11;
    tick(1);
    {fault_event, alarm_reset} = 2'b00;
    tick(2);
    chk(relay_out, 1'b1, "fault beats reset");
    alarm_reset = 1'b1;
    tick(1);
    alarm_reset = 1'b0;
    tick(2);
    chk(relay_out, 1'b0, "alarm cleared");
  endtask
  // Overload thresholds, equality hold and top of range
  task automatic t_overload();
    overload_level_1 = 5'h0A;
    overload_level_2 = 5'h0F;
    set_sel(5'h01, drive_flags_pkg::CODE_OVERLOAD_1);
    set_sel(5'h02, drive_flags_pkg::CODE_OVERLOAD_2);
    output_current = 12'h03E9;
    tick(3);
    chk(terminal_out[0], 1'b1, "ovl1 above");
    chk(terminal_out[1], 1'b0, "ovl2 below");
    output_current = 12'h05DD;
    tick(3);
    chk(terminal_out[1], 1'b1, "ovl2 above");
    output_current = 12'h03E8;
    tick(3);
    chk(terminal_out[0], 1'b1, "ovl1 equal holds");
    chk(terminal_out[1], 1'b0, "ovl2 off");
    output_current = 12'h03E7;
    tick(3);
    chk(terminal_out[0], 1'b0, "ovl1 off");
    overload_level_1 = 5'h14;
    output_current = 12'h07D1;
    tick(3);
    chk(terminal_out[0], 1'b1, "ovl1 at 2.0");
    output_current = 12'h0000;
  endtask
  // PID deviation boundary
  task automatic t_pid();
    set_sel(5'h04, drive_flags_pkg::CODE_PID_DEV);
    pid_deviation_limit = 10'h01E;
    pid_error = 11'h01F;
    tick(3);
    chk(terminal_out[2], 1'b1, "pid above");
    pid_error = 11'h01E;
    tick(3);
    chk(terminal_out[2], 1'b0, "pid at limit");
  endtask
  // Torque in one quadrant against terminal 3
  task automatic tq(input logic signed [9:0] t, input logic r, input logic e);
    torque_est = t;
    dir_reverse = r;
    tick(3);
    chk(terminal_out[3], e, "over torque");
  endtask
  // Four quadrant levels and method gating
  task automatic t_torque();
    set_sel(5'h08, drive_flags_pkg::CODE_OVER_TORQUE);
    motor_control_method = drive_flags_pkg::METHOD_SENSORLESS;
    {torque_level_fwd_drive, torque_level_rev_regen} = 16'h6432;
    {torque_level_rev_drive, torque_level_fwd_regen} = 16'h9650;
    tq(10'sh065, 1'b0, 1'b1);
    tq(10'sh064, 1'b0, 1'b0);
    tq(10'sh033, 1'b1, 1'b1);
    tq(10'sh032, 1'b1, 1'b0);
    tq(10'sh369, 1'b1, 1'b1);
    tq(10'sh36A, 1'b1, 1'b0);
    tq(10'sh3AF, 1'b0, 1'b1);
    tq(10'sh3B0, 1'b0, 1'b0);
    motor_control_method = 3'h0;
    tq(10'sh065, 1'b0, 1'b0);
    motor_control_method = drive_flags_pkg::METHOD_SENSORED;
    tq(10'sh065, 1'b0, 1'b1);
    motor_control_method = drive_flags_pkg::METHOD_ZERO_HZ;
    tq(10'sh065, 1'b0, 1'b1);
  endtask
  // Plain level flags, one at a time, then method gating and an unused code
  task automatic t_levels();
    logic [4:0] codes [5] = '{5'h08, 5'h09, 5'h0A, 5'h0E, 5'h0F};
    motor_control_method = drive_flags_pkg::METHOD_SENSORLESS;
    for (int i = 0; i < 5; i++) begin
      set_sel(5'h01, codes[i]);
      {momentary_power_loss, undervoltage_flag, torque_limit_active, brake_release,
       brake_fault} = 5'h10 >> i;
      tick(3);
      chk(terminal_out[0], 1'b1, "level flag on");
      {momentary_power_loss, undervoltage_flag, torque_limit_active, brake_release,
       brake_fault} = ~(5'h10 >> i);
      tick(3);
      chk(terminal_out[0], 1'b0, "level flag off");
    end
    torque_limit_active = 1'b1;
    motor_control_method = 3'h0;
    set_sel(5'h01, drive_flags_pkg::CODE_TORQUE_LIM);
    tick(3);
    chk(terminal_out[0], 1'b0, "torque limit gated");
    set_sel(5'h01, 5'h06);
    tick(3);
    chk(terminal_out[0], 1'b0, "unused code");
  endtask
  // Shared hours limit with separate counters
  task automatic t_hours();
    set_sel(5'h01, drive_flags_pkg::CODE_RUN_HOURS);
    set_sel(5'h02, drive_flags_pkg::CODE_ON_HOURS);
    hours_limit = 14'h0000;
    tick(3);
    chk(terminal_out[0], 1'b1, "run hours zero");
    hours_limit = 14'h270F;
    tick(3);
    chk(terminal_out[1], 1'b0, "on hours below");
    hours_limit = 14'h0001;
    tick(3);
    chk(terminal_out[0], 1'b0, "no run yet");
    chk(terminal_out[1], 1'b1, "on hours reached");
    running = 1'b1;
    tick(25);
    chk(terminal_out[0], 1'b1, "run hours reached");
    running = 1'b0;
  endtask
  // Thermal warning boundary
  task automatic t_thermal();
    set_sel(5'h01, drive_flags_pkg::CODE_THERMAL);
    thermal_warning_level = 10'h1F4;
    thermal_value = 10'h1F3;
    tick(3);
    chk(terminal_out[0], 1'b0, "thermal below");
    thermal_value = 10'h1F4;
    tick(3);
    chk(terminal_out[0], 1'b1, "thermal at level");
  endtask
  // Zero speed source by method
  task automatic t_zero();
    set_sel(5'h01, drive_flags_pkg::CODE_ZERO_SPEED);
    zero_speed_level = 14'h0064;
    motor_control_method = drive_flags_pkg::METHOD_SENSORED;
    {rotor_freq, ramp_output} = 32'h0032_00C8;
    tick(3);
    chk(terminal_out[0], 1'b1, "rotor source");
    motor_control_method = 3'h0;
    tick(3);
    chk(terminal_out[0], 1'b0, "ramp source");
    ramp_output = 16'h0063;
    tick(3);
    chk(terminal_out[0], 1'b1, "ramp below");
    ramp_output = 16'h0064;
    tick(3);
    chk(terminal_out[0], 1'b0, "ramp at level");
  endtask
  // Overload restriction lowers frequency
  task automatic t_restrict();
    restrict_level = 5'h0A;
    ramp_output = 16'h01F4;
    accelerating = 1'b1;
    output_current = 12'h03E7;
    tick(3);
    chk(restricting, 1'b0, "no restriction");
    chk(freq_out === 16'h01F4, 1'b1, "freq follows");
    output_current = 12'h03E8;
    tick(2);
    chk(restricting, 1'b1, "restricting");
    {accelerating, constant_speed} = 2'b01;
    tick(20);
    chk(freq_out < 16'h01F4 && freq_out >= 16'h01EE, 1'b1, "freq lowered");
    constant_speed = 1'b0;
    tick(3);
    chk(restricting, 1'b0, "decel stops");
    chk(freq_out === 16'h01F4, 1'b1, "freq back");
  endtask
  // Verdict
  task automatic results();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {sel_wr, sel_data, overload_level_1, overload_level_2, restrict_level} = '0;
    {output_current, accelerating, constant_speed, fault_event, alarm_reset} = '0;
    {pid_error, pid_deviation_limit, thermal_value, thermal_warning_level} = '0;
    {torque_est, dir_reverse, motor_control_method, running, hours_limit} = '0;
    {torque_level_fwd_drive, torque_level_rev_regen} = '0;
    {torque_level_rev_drive, torque_level_fwd_regen} = '0;
    {momentary_power_loss, undervoltage_flag, torque_limit_active} = '0;
    {brake_release, brake_fault, zero_speed_level, ramp_output, rotor_freq} = '0;
    tick(10);
    rst_n = 1'b1;
    tick(1);
    chk(terminal_out === 4'h0 && relay_out === 1'b0, 1'b1, "idle outputs");
    t_alarm();
    t_overload();
    t_pid();
    t_torque();
    t_levels();
    t_hours();
    t_thermal();
    t_zero();
    t_restrict();
    results();
  end
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    results();
  end
endmodule
